// [design/tpp_pkg.sv]
// tpp_pkg: constants and types for the cooler parameter panel logic
// assumes a 10 MHz hclk and debounced-free raw front-panel levels
package tpp_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int HOLD_S = 3;
    localparam int HOLD_CYC = CLK_HZ * HOLD_S;
    localparam int FLASH1_HZ = 1;
    localparam int FLASH2_HZ = 2;
    localparam int HALF1_CYC = CLK_HZ / (2 * FLASH1_HZ);
    localparam int HALF2_CYC = CLK_HZ / (2 * FLASH2_HZ);
    // coefficient in thousandths, signed 16 bits
    localparam logic signed [15:0] COEF_MAX = 16'sh270f;
    localparam logic signed [15:0] COEF_MIN = -16'sh270f;
    localparam logic [15:0] VAL_MAX = 16'hffff;
    localparam logic [2:0] GAIN_LAST = 3'h5;
    localparam logic [7:0] PCT_FULL = 8'h64;
    // bus map, byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_LIM = 8'h08;
    localparam logic [7:0] A_THI = 8'h0c;
    localparam logic [7:0] A_C1 = 8'h10;
    localparam logic [7:0] A_C2 = 8'h14;
    localparam logic [7:0] A_C3 = 8'h18;
    localparam logic [7:0] A_GAIN = 8'h1c;
    localparam logic [7:0] A_MEAS = 8'h20;
    // ctrl bits
    localparam int C_ADJ_TEC = 0;
    localparam int C_REMOTE = 1;
    localparam int C_THI_OFF_DIS = 2;
    localparam int C_BOOSTER = 3;
    localparam int C_ON_TOGGLE = 4;
    localparam int C_MODE_LSB = 5;
    localparam logic [31:0] CTRL_RST = 32'h0000_0008 & 32'h0;
    localparam logic [15:0] LIM_RST = 16'h07d0;
    localparam logic [15:0] THI_RST = 16'h0032;
    typedef enum logic [2:0] {P_LIM, P_THI, P_C1, P_C2, P_C3, P_GAIN} tpp_par_e;
    typedef enum logic [1:0] {S_IDLE, S_SELECT, S_SET} tpp_state_e;
endpackage : tpp_pkg

// [design/tpp_panel.sv]
// tpp_panel: cooler parameter panel, fault lamps and output enable
// assumes raw panel inputs asynchronous; measurements arrive over AHB-Lite
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module tpp_panel
    import tpp_pkg::*;
#(
    parameter int HOLD_CYCLES = tpp_pkg::HOLD_CYC,
    parameter int HALF1 = tpp_pkg::HALF1_CYC,
    parameter int HALF2 = tpp_pkg::HALF2_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic select_btn,
    input wire logic set_btn,
    input wire logic knob_up,
    input wire logic knob_down,
    input wire logic sensor_linear,
    input wire logic sensor_open,
    input wire logic module_open,
    input wire logic compliance_hit,
    output logic [5:0] param_lamps,
    output logic display_lamps_off,
    output logic [9:0] bar_graph,
    output logic bar_negative,
    output logic drive_ceiling_lamp,
    output logic temp_limit_lamp,
    output logic sensor_open_lamp,
    output logic cooler_disconnected_lamp,
    output logic cooler_out_on,
    output logic use_linear,
    output logic nv_write,
    output logic [2:0] nv_index,
    output logic [15:0] nv_data
);
    import tpp_pkg::*;

    typedef struct packed {
        logic [9:0] s1;
        logic [9:0] s2;
        logic [9:0] pv;
        tpp_state_e st;
        tpp_par_e par;
        logic [31:0] timer;
        logic [31:0] c1;
        logic [31:0] c2;
        logic ph1;
        logic ph2;
        logic [31:0] ctrl;
        logic [15:0] lim;
        logic [15:0] thi;
        logic [15:0] c1v;
        logic [15:0] c2v;
        logic [15:0] c3v;
        logic [2:0] gain;
        logic [15:0] meas_i;
        logic [15:0] meas_t;
        logic [1:0] mode;
        logic d_wr;
        logic [7:0] d_addr;
        logic [31:0] rdata;
        logic [5:0] plamp;
        logic doff;
        logic [9:0] bar;
        logic bneg;
        logic lamp_i;
        logic lamp_t;
        logic lamp_s;
        logic lamp_m;
        logic on;
        logic lin;
        logic nvw;
        logic [2:0] nvi;
        logic [15:0] nvd;
        logic hro;
        logic hrsp;
    } tpp_s;

    tpp_s q;
    tpp_s n;

    // positions of the panel levels inside the synchroniser word
    localparam int B_CMP = 2;
    localparam int B_MOD = 3;
    localparam int B_SENS = 4;
    localparam int B_LIN = 5;
    localparam int B_SEL = 6;
    localparam int B_SET = 7;
    localparam int B_KUP = 8;
    localparam int B_KDN = 9;

    // one-hot decode of the selected parameter, used for the parameter lamps
    function automatic logic [5:0] par_hot(input tpp_par_e p);
        par_hot = 6'h01 << p;
    endfunction : par_hot

    function automatic logic [15:0] par_val(input tpp_s s);
        case (s.par)
            P_LIM: par_val = s.lim;
            P_THI: par_val = s.thi;
            P_C1: par_val = s.c1v;
            P_C2: par_val = s.c2v;
            P_C3: par_val = s.c3v;
            default: par_val = {13'h0, s.gain};
        endcase
    endfunction : par_val

    function automatic logic [15:0] coef_step(input logic [15:0] v,
                                              input logic up);
        logic signed [16:0] t;
        t = up ? $signed({v[15], v}) + 17'sh1 : $signed({v[15], v}) - 17'sh1;
        if (t > $signed({COEF_MAX[15], COEF_MAX}))
            coef_step = COEF_MAX;
        else if (t < $signed({COEF_MIN[15], COEF_MIN}))
            coef_step = COEF_MIN;
        else
            coef_step = t[15:0];
    endfunction : coef_step

    // bus writes are clamped too, so a stored coefficient is never out of range
    function automatic logic [15:0] coef_fit(input logic [15:0] v);
        if ($signed(v) > COEF_MAX)
            coef_fit = COEF_MAX;
        else if ($signed(v) < COEF_MIN)
            coef_fit = COEF_MIN;
        else
            coef_fit = v;
    endfunction : coef_fit

    function automatic logic [15:0] uns_step(input logic [15:0] v,
                                             input logic up);
        if (up)
            uns_step = (v == VAL_MAX) ? v : v + 16'h1;
        else
            uns_step = (v == 16'h0) ? v : v - 16'h1;
    endfunction : uns_step

    logic [9:0] raw;
    assign raw = {knob_down, knob_up, set_btn, select_btn, sensor_linear,
                  sensor_open, module_open, compliance_hit, 2'h0};

    always_comb
    begin
        logic [9:0] ed;
        logic sel_rise;
        logic set_rise;
        logic set_fall;
        logic k_up;
        logic k_dn;
        logic adj;
        logic at_lim;
        logic at_thi;
        logic [31:0] pct;
        logic [15:0] mag;
        logic [1:0] new_mode;
        // locals start at zero so that no path leaves one unassigned
        pct = 32'h0;
        mag = 16'h0;
        at_lim = 1'b0;
        at_thi = 1'b0;
        new_mode = 2'h0;
        n = q;
        ed = q.s2 & ~q.pv;
        sel_rise = ed[B_SEL];
        set_rise = ed[B_SET];
        set_fall = q.pv[B_SET] & ~q.s2[B_SET];
        k_up = ed[B_KUP];
        k_dn = ed[B_KDN];
        adj = q.ctrl[C_ADJ_TEC];
        n.s1 = raw;
        n.s2 = q.s1;
        n.pv = q.s2;
        n.nvw = 1'b0;
        n.d_wr = 1'b0;
        // free-running dividers: all lamps of one rate flash in step
        if (q.c1 >= 32'(HALF1 - 1))
        begin
            n.c1 = 32'h0;
            n.ph1 = ~q.ph1;
        end
        else
            n.c1 = q.c1 + 32'h1;
        if (q.c2 >= 32'(HALF2 - 1))
        begin
            n.c2 = 32'h0;
            n.ph2 = ~q.ph2;
        end
        else
            n.c2 = q.c2 + 32'h1;
        // panel state machine
        case (q.st)
            S_IDLE:
            begin
                if (sel_rise && adj)
                begin
                    n.st = S_SELECT;
                    n.par = P_LIM;
                    n.timer = 32'h0;
                end
            end
            S_SELECT:
            begin
                // the hold timer only runs with select released
                if (q.s2[B_SEL])
                    n.timer = 32'h0;
                else
                    n.timer = q.timer + 32'h1;
                if (!adj)
                    n.st = S_IDLE;
                else if (sel_rise)
                begin
                    n.par = (q.par == P_GAIN) ? P_LIM
                            : tpp_par_e'(q.par + 3'h1);
                    n.timer = 32'h0;
                end
                else if (set_rise)
                    n.st = S_SET;
                else if (q.timer >= 32'(HOLD_CYCLES - 1))
                    n.st = S_IDLE;
            end
            S_SET:
            begin
                if (k_up ^ k_dn)
                begin
                    case (q.par)
                        P_LIM: n.lim = uns_step(q.lim, k_up);
                        P_THI: n.thi = uns_step(q.thi, k_up);
                        P_C1: n.c1v = coef_step(q.c1v, k_up);
                        P_C2: n.c2v = coef_step(q.c2v, k_up);
                        P_C3: n.c3v = coef_step(q.c3v, k_up);
                        default:
                            if (k_up && q.gain != GAIN_LAST)
                                n.gain = q.gain + 3'h1;
                            else if (k_dn && q.gain != 3'h0)
                                n.gain = q.gain - 3'h1;
                    endcase
                end
                // one storage write per release, however many steps came first
                if (set_fall)
                begin
                    n.nvw = 1'b1;
                    n.nvi = q.par;
                    n.nvd = par_val(q);
                    n.st = S_SELECT;
                    n.timer = 32'h0;
                end
            end
            default: n.st = S_IDLE;
        endcase
        // AHB-Lite slave: zero wait states, always OKAY; both held in flops
        // so that every port of the block leaves a register
        n.hro = 1'b1;
        n.hrsp = 1'b0;
        if (q.d_wr)
        begin
            case (q.d_addr)
                A_CTRL: n.ctrl = hwdata;
                // software may preset values; knob edits start from there
                A_LIM: n.lim = hwdata[15:0];
                A_THI: n.thi = hwdata[15:0];
                A_C1: n.c1v = coef_fit(hwdata[15:0]);
                A_C2: n.c2v = coef_fit(hwdata[15:0]);
                A_C3: n.c3v = coef_fit(hwdata[15:0]);
                // an out-of-range gain index sticks at the top step
                A_GAIN:
                    n.gain = (hwdata[2:0] > GAIN_LAST) ? GAIN_LAST
                             : hwdata[2:0];
                A_MEAS:
                begin
                    n.meas_i = hwdata[15:0];
                    n.meas_t = hwdata[31:16];
                end
                default: n.ctrl = q.ctrl;
            endcase
        end
        if (hsel && hready && htrans[1])
        begin
            n.d_wr = hwrite;
            n.d_addr = haddr[7:0];
            case (haddr[7:0])
                A_CTRL: n.rdata = q.ctrl;
                A_STAT: n.rdata = {24'h0, q.on, q.lamp_m, q.lamp_s, q.lamp_t,
                                   q.lamp_i, q.st == S_SET, q.st == S_SELECT,
                                   q.lin};
                A_LIM: n.rdata = {16'h0, q.lim};
                A_THI: n.rdata = {16'h0, q.thi};
                A_C1: n.rdata = {{16{q.c1v[15]}}, q.c1v};
                A_C2: n.rdata = {{16{q.c2v[15]}}, q.c2v};
                A_C3: n.rdata = {{16{q.c3v[15]}}, q.c3v};
                A_GAIN: n.rdata = {29'h0, q.gain};
                A_MEAS: n.rdata = {q.meas_t, q.meas_i};
                default: n.rdata = 32'h0;
            endcase
        end
        // output enable and faults
        // current magnitude; the sign only drives the polarity lamp
        mag = q.meas_i[15] ? (~q.meas_i + 16'h1) : q.meas_i;
        // limit needs the output on, so a remote shut-off also ends the flash
        at_lim = q.on && (mag >= q.lim);
        at_thi = $signed(q.meas_t) >= $signed(q.thi);
        new_mode = q.ctrl[C_MODE_LSB +: 2];
        n.mode = new_mode;
        if (q.d_wr && q.d_addr == A_CTRL && hwdata[C_ON_TOGGLE])
            n.on = ~q.on;
        if (new_mode != q.mode)
            n.on = 1'b0;
        if (at_lim && q.ctrl[C_REMOTE])
            n.on = 1'b0;
        if (at_thi && !q.ctrl[C_THI_OFF_DIS])
            n.on = 1'b0;
        if (q.s2[B_SENS])
            n.on = 1'b0;
        n.lamp_i = (q.s2[B_CMP] && q.ph2)
                   || (!q.s2[B_CMP] && at_lim && q.ph1);
        n.lamp_t = at_thi && q.ph1;
        n.lamp_s = q.s2[B_SENS] && q.ph1;
        n.lamp_m = q.s2[B_MOD] && !q.ctrl[C_BOOSTER] && q.ph1;
        n.lin = q.s2[B_LIN];
        n.plamp = (q.st == S_IDLE) ? 6'h0 : par_hot(q.par);
        n.doff = q.st != S_IDLE;
        n.bneg = 1'b0;
        n.bar = 10'h0;
        if (q.st != S_IDLE && q.par >= P_C1 && q.par <= P_C3)
            n.bar = 10'h1 << (q.par - P_C1);
        else if (q.on && q.lim != 16'h0)
        begin
            pct = ({16'h0, mag} * 32'(PCT_FULL)) / {16'h0, q.lim};
            if (pct > 32'(PCT_FULL))
                pct = 32'(PCT_FULL);
            n.bar = ~(10'h3ff << pct[7:0] / 8'd10);
            n.bneg = q.meas_i[15];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.lim <= LIM_RST;
            q.thi <= THI_RST;
            q.hro <= 1'b1;
        end
        else
            q <= n;
    end

    assign hrdata = q.rdata;
    assign hreadyout = q.hro;
    assign hresp = q.hrsp;
    assign param_lamps = q.plamp;
    assign display_lamps_off = q.doff;
    assign bar_graph = q.bar;
    assign bar_negative = q.bneg;
    assign drive_ceiling_lamp = q.lamp_i;
    assign temp_limit_lamp = q.lamp_t;
    assign sensor_open_lamp = q.lamp_s;
    assign cooler_disconnected_lamp = q.lamp_m;
    assign cooler_out_on = q.on;
    assign use_linear = q.lin;
    assign nv_write = q.nvw;
    assign nv_index = q.nvi;
    assign nv_data = q.nvd;
endmodule : tpp_panel

// [sim/tpp_operator.sv]
// tpp_operator: behavioural operator at the buttons and knob
// assumes the panel synchronises raw levels over two flops
`timescale 1ns/100ps
module tpp_operator
(
    input wire logic hclk,
    output logic select_btn,
    output logic set_btn,
    output logic knob_up,
    output logic knob_down
);
    // the knob turns one way per call; clamps are reached from preset values
    initial
    begin
        select_btn = 1'b0;
        set_btn = 1'b0;
        knob_up = 1'b0;
        knob_down = 1'b0;
    end
    task automatic tap();
        select_btn <= 1'b1;
        repeat (4) @(posedge hclk);
        select_btn <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : tap
    task automatic press_set(input logic v);
        set_btn <= v;
        repeat (4) @(posedge hclk);
    endtask : press_set
    task automatic turn(input int n, input logic up);
        repeat (n)
        begin
            if (up)
                knob_up <= 1'b1;
            else
                knob_down <= 1'b1;
            repeat (3) @(posedge hclk);
            knob_up <= 1'b0;
            knob_down <= 1'b0;
            repeat (3) @(posedge hclk);
        end
    endtask : turn
endmodule : tpp_operator

// [sim/tpp_panel_props.sv]
// tpp_panel_props: port checks on the cooler parameter panel
// assumes a bind onto tpp_panel with its hold count handed on
`timescale 1ns/100ps
module tpp_panel_props
    import tpp_pkg::*;
#(
    parameter int HOLD_CYCLES = HOLD_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic select_btn,
    input wire logic set_btn,
    input wire logic sensor_open,
    input wire logic module_open,
    input logic [5:0] param_lamps,
    input logic display_lamps_off,
    input logic [9:0] bar_graph,
    input logic sensor_open_lamp,
    input logic cooler_disconnected_lamp,
    input logic cooler_out_on,
    input logic nv_write,
    input logic [2:0] nv_index,
    input logic [15:0] nv_data
);
    int idle_cnt;
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // slack of 8 covers input synchronisers
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            idle_cnt <= 0;
        else if (display_lamps_off && !select_btn && !set_btn)
            idle_cnt <= idle_cnt + 1;
        else
            idle_cnt <= 0;
    hold_expire_a: assert property (idle_cnt <= HOLD_CYCLES + 8)
        else $error("select state outlived its hold");
    entry_lamp_a: assert property
        ($rose(display_lamps_off) |-> param_lamps == 6'h01)
        else $error("select entry not at current limit");
    lamp_blank_a: assert property
        (param_lamps != 6'h0 |-> display_lamps_off && $onehot(param_lamps))
        else $error("parameter lamps wrong");
    advance_a: assert property
        (param_lamps != 6'h0 && $past(param_lamps) != 6'h0
        && $changed(param_lamps) |->
        param_lamps == {$past(param_lamps[4:0]), $past(param_lamps[5])})
        else $error("parameter order broken");
    coef_bar_a: assert property
        (param_lamps[4:2] != 3'h0 && $stable(param_lamps) |->
        bar_graph[2:0] == param_lamps[4:2])
        else $error("coefficient bar wrong");
    nv_single_a: assert property (nv_write |=> !nv_write)
        else $error("storage write longer than one cycle");
    coef_clamp_a: assert property
        (nv_write && nv_index inside {3'h2, 3'h3, 3'h4} |->
        $signed(nv_data) <= COEF_MAX && $signed(nv_data) >= COEF_MIN)
        else $error("coefficient out of range");
    gain_range_a: assert property
        (nv_write && nv_index == 3'h5 |-> nv_data <= {13'h0, GAIN_LAST})
        else $error("gain index out of range");
    sens_off_a: assert property (sensor_open [*5] |-> !cooler_out_on)
        else $error("output on with open sensor");
    sens_lamp_a: assert property
        (!sensor_open [*5] |-> !sensor_open_lamp)
        else $error("sensor lamp without fault");
    mod_lamp_a: assert property
        (!module_open [*5] |-> !cooler_disconnected_lamp)
        else $error("module lamp without fault");
endmodule : tpp_panel_props
bind tpp_panel tpp_panel_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_tpp_panel_props
(
    .hclk(hclk), .hresetn(hresetn), .select_btn(select_btn),
    .set_btn(set_btn), .sensor_open(sensor_open), .module_open(module_open),
    .param_lamps(param_lamps), .display_lamps_off(display_lamps_off),
    .bar_graph(bar_graph), .sensor_open_lamp(sensor_open_lamp),
    .cooler_disconnected_lamp(cooler_disconnected_lamp),
    .cooler_out_on(cooler_out_on), .nv_write(nv_write),
    .nv_index(nv_index), .nv_data(nv_data)
);

// [sim/tpp_panel_test.sv]
// tpp_panel_test: bus and panel sequences with expected values
// assumes short hold and flash counts; the knob is turned both ways
`timescale 1ns/100ps
module tpp_panel_test;
    import tpp_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic sensor_linear = 1'b0;
    logic sensor_open = 1'b0;
    logic module_open = 1'b0;
    logic compliance_hit = 1'b0;
    logic select_btn, set_btn, knob_up, knob_down, hreadyout, hresp;
    logic display_lamps_off, bar_negative, use_linear, nv_write;
    logic drive_ceiling_lamp, temp_limit_lamp, sensor_open_lamp;
    logic cooler_disconnected_lamp, cooler_out_on;
    logic [31:0] hrdata;
    logic [5:0] param_lamps;
    logic [9:0] bar_graph;
    logic [2:0] nv_index;
    logic [15:0] nv_data;
    logic [3:0] lamps;
    int error_cnt = 0;
    int samples_checked = 0;
    int nv_cnt = 0;
    assign lamps = {cooler_disconnected_lamp, sensor_open_lamp,
        temp_limit_lamp, drive_ceiling_lamp};
    always #50 hclk = ~hclk;
    always @(posedge hclk)
        if (nv_write === 1'b1)
            nv_cnt <= nv_cnt + 1;
    tpp_panel #(.HOLD_CYCLES(50), .HALF1(10), .HALF2(5)) u_tpp_panel
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .select_btn(select_btn), .set_btn(set_btn),
        .knob_up(knob_up), .knob_down(knob_down),
        .sensor_linear(sensor_linear), .sensor_open(sensor_open),
        .module_open(module_open), .compliance_hit(compliance_hit),
        .param_lamps(param_lamps), .display_lamps_off(display_lamps_off),
        .bar_graph(bar_graph), .bar_negative(bar_negative),
        .drive_ceiling_lamp(drive_ceiling_lamp),
        .temp_limit_lamp(temp_limit_lamp),
        .sensor_open_lamp(sensor_open_lamp),
        .cooler_disconnected_lamp(cooler_disconnected_lamp),
        .cooler_out_on(cooler_out_on), .use_linear(use_linear),
        .nv_write(nv_write), .nv_index(nv_index), .nv_data(nv_data)
    );
    tpp_operator u_tpp_operator
    (
        .hclk(hclk), .select_btn(select_btn), .set_btn(set_btn),
        .knob_up(knob_up), .knob_down(knob_down)
    );
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    task automatic rdy();
        int n;
        n = 0;
        cyc(1);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                error_cnt++;
                finish_test();
            end
            cyc(1);
        end
    endtask : rdy
    // read data is taken at the edge that ends the data phase
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk("reg", e, r);
    endtask : rc
    task automatic half(input int i, input int e);
        int n;
        // let the fault settle so that a cut first phase is not measured
        cyc(4);
        for (n = 0; n < 60 && lamps[i] !== 1'b0; n++) cyc(1);
        for (n = 0; n < 60 && lamps[i] !== 1'b1; n++) cyc(1);
        for (n = 0; n < 60 && lamps[i] === 1'b1; n++) cyc(1);
        chk("flash", e, n);
    endtask : half
    task automatic adjust(input int n, input logic up);
        u_tpp_operator.press_set(1'b1);
        u_tpp_operator.turn(n, up);
        u_tpp_operator.press_set(1'b0);
        cyc(10);
    endtask : adjust
    task automatic out_is(input logic e, input int n);
        cyc(n);
        chk("out", e, cooler_out_on);
    endtask : out_is
    initial
    begin
        cyc(2);
        hresetn <= 1'b1;
        cyc(1);
        rc(A_LIM, {16'h0, LIM_RST});
        rc(A_THI, {16'h0, THI_RST});
        rc(8'h24, 32'h0);
        chk("resp", 0, hresp);
        sensor_linear <= 1'b1;
        cyc(6);
        chk("linear", 1, use_linear);
        rc(A_STAT, 32'h1);
        rc(A_C1, 32'h0);
        u_tpp_operator.tap();
        chk("lamps", 0, param_lamps);
        wr(A_CTRL, 32'h1);
        u_tpp_operator.tap();
        chk("lamps", 1, param_lamps);
        chk("blank", 1, display_lamps_off);
        for (int i = 1; i < 9; i++)
        begin
            u_tpp_operator.tap();
            chk("lamps", 6'h1 << (i % 6), param_lamps);
            if (i % 6 >= 2 && i % 6 <= 4)
                chk("bar", 3'h1 << (i % 6 - 2), bar_graph[2:0]);
        end
        wr(A_C1, 32'h270e);
        u_tpp_operator.turn(2, 1'b1);
        rc(A_C1, 32'h270e);
        adjust(3, 1'b1);
        chk("nv count", 1, nv_cnt);
        chk("nv index", 2, nv_index);
        chk("nv data", 32'h270f, nv_data);
        repeat (3) u_tpp_operator.tap();
        wr(A_GAIN, 32'h4);
        adjust(3, 1'b1);
        chk("nv count", 2, nv_cnt);
        chk("nv index", 5, nv_index);
        chk("nv data", 5, nv_data);
        adjust(6, 1'b0);
        chk("nv count", 3, nv_cnt);
        chk("nv data", 0, nv_data);
        cyc(30);
        chk("blank", 1, display_lamps_off);
        cyc(40);
        chk("blank", 0, display_lamps_off);
        adjust(0, 1'b1);
        chk("nv count", 3, nv_cnt);
        chk("lamps", 0, param_lamps);
        wr(A_CTRL, 32'h11);
        out_is(1'b1, 3);
        wr(A_MEAS, 32'h3e8);
        cyc(4);
        chk("bar", 10'h1f, bar_graph);
        wr(A_MEAS, 32'hfc18);
        cyc(4);
        chk("sign", 1, bar_negative);
        chk("bar", 10'h1f, bar_graph);
        wr(A_CTRL, 32'h21);
        out_is(1'b0, 3);
        wr(A_MEAS, 32'h0);
        wr(A_CTRL, 32'h31);
        out_is(1'b1, 3);
        wr(A_MEAS, {16'h0, LIM_RST});
        half(0, 10);
        chk("out", 1, cooler_out_on);
        compliance_hit <= 1'b1;
        half(0, 5);
        compliance_hit <= 1'b0;
        wr(A_CTRL, 32'h23);
        out_is(1'b0, 4);
        wr(A_MEAS, 32'h0);
        wr(A_CTRL, 32'h31);
        wr(A_MEAS, 32'h7fff_0000);
        out_is(1'b0, 4);
        half(1, 10);
        wr(A_CTRL, 32'h25);
        wr(A_CTRL, 32'h35);
        out_is(1'b1, 4);
        wr(A_MEAS, 32'h0);
        wr(A_CTRL, 32'h21);
        out_is(1'b1, 3);
        sensor_open <= 1'b1;
        out_is(1'b0, 6);
        half(2, 10);
        sensor_open <= 1'b0;
        module_open <= 1'b1;
        half(3, 10);
        wr(A_CTRL, 32'h29);
        cyc(5);
        for (int i = 0; i < 20; i++)
        begin
            cyc(1);
            chk("module", 0, cooler_disconnected_lamp);
        end
        finish_test();
    end
endmodule : tpp_panel_test
